// File: rtl/spp_cfg.svh
// constants for the switch port policy block: offsets, fields, resets, timing
//
// Contract
// - each external port runs fixed 10, fixed 100, or auto-negotiated rate
// - each external port runs full, half, or auto-negotiated duplex
// - advertise option keeps advertising fixed settings; enabled after reset
// - limiter modes off, broadcast capped 128 kbit/s; broadcast is default
// - third mode caps multicast plus broadcast at 1024 kbit/s, drops excess
// - per ingress port a permitted destination set gates forwarding
// - all forwarding permissions between the three ports active after reset
// - send periodic discovery frames and accept neighbours' discovery frames
// - discovery only on external ports, off after reset
// - send-only: transmit discovery, discard received discovery frames
// - receive-only: no discovery transmit, deliver received ones
// - combined: transmit discovery and deliver received ones
// - egress mirroring copies every transmitted frame to mirror port; the code does not copy frames that came in on the destination port
// - ingress mirroring copies every received frame to mirror port
// - combined mirroring copies both directions to mirror port
// - destination port emits copies; off ports excluded; off after reset
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// register map, byte addresses
`define SPP_ADDR_W 8
`define SPP_REG_CFG_A 8'h00
`define SPP_REG_CFG_B 8'h04
`define SPP_REG_FWD 8'h08
`define SPP_REG_DISC 8'h0C
`define SPP_REG_MIR 8'h10
`define SPP_REG_STAT 8'h14
`define SPP_REG_LIM_DROP 8'h18
`define SPP_REG_MIR_DROP 8'h1C

// port configuration word
`define SPP_CFG_W 7
`define SPP_CFG_SPD_LSB 0
`define SPP_CFG_DUP_LSB 2
`define SPP_CFG_ADV_BIT 4
`define SPP_CFG_LIM_LSB 5
`define SPP_CFG_RST 7'h30

// per-port field strides in matrix, discovery and mirror words
`define SPP_FWD_STRIDE 4
`define SPP_FWD_RST 12'h356
`define SPP_DISC_STRIDE 2
`define SPP_MIR_STRIDE 4

// port indices
`define SPP_PORT_A 2'h0
`define SPP_PORT_B 2'h1
`define SPP_PORT_CPU 2'h2

// rates and timing
`define SPP_CLK_HZ 20000000
`define SPP_LIM_BC_KBPS 11'h080
`define SPP_LIM_MC_KBPS 11'h400
`define SPP_CREDIT_THR (`SPP_CLK_HZ * 8 / 1000)
`define SPP_BKT_BYTES 2048
`define SPP_LEN_W 11
`define SPP_DISC_PERIOD_MS 30000
`define SPP_DISC_PERIOD_CYC (`SPP_DISC_PERIOD_MS * (`SPP_CLK_HZ / 1000))
`define SPP_CNT_W 16

`endif

// File: rtl/spp_pkg.sv
// types for the switch port policy block
package spp_pkg;
    typedef enum logic [1:0] {SPP_SPD_ANEG = 2'h0, SPP_SPD_10 = 2'h1,
        SPP_SPD_100 = 2'h2} spp_speed_t;
    typedef enum logic [1:0] {SPP_DUP_ANEG = 2'h0, SPP_DUP_FULL = 2'h1,
        SPP_DUP_HALF = 2'h2} spp_dup_t;
    typedef enum logic [1:0] {SPP_LIM_OFF = 2'h0, SPP_LIM_BC = 2'h1,
        SPP_LIM_MCBC = 2'h2} spp_lim_t;
    typedef enum logic [1:0] {SPP_DISC_OFF = 2'h0, SPP_DISC_SEND = 2'h1,
        SPP_DISC_RECV = 2'h2, SPP_DISC_BOTH = 2'h3} spp_disc_t;
    typedef enum logic [2:0] {SPP_MIR_OFF = 3'h0, SPP_MIR_EGR = 3'h1,
        SPP_MIR_ING = 3'h2, SPP_MIR_BOTH = 3'h3,
        SPP_MIR_DEST = 3'h4} spp_mir_t;
endpackage

// File: rtl/spp_sync2.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module spp_sync2 #(
    parameter int W = 1
)(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_ff;

    // first stage is read only by the second
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            meta_ff <= '0;
            o_q <= '0;
        end
        else
        begin
            meta_ff <= i_d;
            o_q <= meta_ff;
        end
    end
endmodule // spp_sync2

// File: rtl/spp_rate_limiter.sv
// token bucket limiter for one external port
`timescale 1ns/1ps
`include "spp_cfg.svh"
module spp_rate_limiter #(
    parameter int LEN_W = `SPP_LEN_W,
    parameter int BKT_W = 12,
    parameter logic [BKT_W-1:0] BKT_MAX = BKT_W'(`SPP_BKT_BYTES)
)(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [10:0] i_rate_kbps,
    input wire logic [LEN_W-1:0] i_len,
    input wire logic i_charge,
    output logic o_ok
);
    localparam logic [17:0] THR = 18'(`SPP_CREDIT_THR);
    logic [17:0] acc_ff;
    logic [17:0] acc_sum;
    logic credit;
    logic [BKT_W-1:0] tok_ff;
    logic [BKT_W-1:0] nxt_tok;

    // fractional accumulator: one byte of credit per THR kbit-cycles
    assign acc_sum = acc_ff + 18'(i_rate_kbps);
    assign credit = (acc_sum >= THR);

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            acc_ff <= '0;
        else
            acc_ff <= credit ? acc_sum - THR : acc_sum;
    end

    // a frame passes only if the whole frame fits in the bucket
    assign o_ok = (tok_ff >= BKT_W'(i_len));

    // refill at rate, charge per byte of an accepted frame
    always_comb
    begin
        nxt_tok = tok_ff;
        if (i_charge && o_ok)
            nxt_tok = nxt_tok - BKT_W'(i_len);
        if (credit && nxt_tok < BKT_MAX)
            nxt_tok = nxt_tok + 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            tok_ff <= BKT_MAX;
        else
            tok_ff <= nxt_tok;
    end
endmodule // spp_rate_limiter

// File: rtl/spp_switch_port_policy.sv
// port policy for a three-port switch: phy modes, limiter, matrix, mirror
`timescale 1ns/1ps
`include "spp_cfg.svh"
module spp_switch_port_policy
    import spp_pkg::*;
#(
    parameter int LEN_W = `SPP_LEN_W,
    parameter int DISC_PERIOD_CYC = `SPP_DISC_PERIOD_CYC
)(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    input wire logic [`SPP_ADDR_W-1:0] I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [31:0] O_REG_RDATA,
    input wire logic [1:0] I_LINK_100,
    input wire logic [1:0] I_LINK_FULL,
    output logic [1:0] O_ANEG_EN,
    output logic [1:0] O_FORCE_100,
    output logic [1:0] O_FORCE_FULL,
    output logic [7:0] O_ADV_ABIL,
    input wire logic I_RX_VALID,
    input wire logic [1:0] I_RX_PORT,
    input wire logic [LEN_W-1:0] I_RX_LEN,
    input wire logic I_RX_BCAST,
    input wire logic I_RX_MCAST,
    input wire logic I_RX_DISC,
    input wire logic [2:0] I_RX_DEST,
    input wire logic I_MIR_READY,
    output logic O_DEC_VALID,
    output logic [2:0] O_DEC_FWD,
    output logic O_DEC_DROP,
    output logic O_DEC_DISC_DELIVER,
    output logic O_DEC_MIRROR,
    output logic [1:0] O_MIR_PORT,
    output logic [1:0] O_DISC_SEND
);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [`SPP_CFG_W-1:0] port_cfg_ff [0:1];
    logic [2:0] fwd_ff [0:2];
    logic [1:0] disc_ff [0:1];
    logic [2:0] mir_ff [0:2];
    logic [`SPP_CNT_W-1:0] lim_drop_ff;
    logic [`SPP_CNT_W-1:0] mir_drop_ff;
    localparam logic [11:0] FWD_RST = `SPP_FWD_RST; // a literal cannot be sliced
    logic [1:0] link_100_s;
    logic [1:0] link_full_s;
    logic [1:0] eff_100;
    logic [1:0] eff_full;

    // per-port speed, duplex, advertise and limiter words
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            port_cfg_ff[0] <= `SPP_CFG_RST;
            port_cfg_ff[1] <= `SPP_CFG_RST;
        end
        else if (I_REG_WR && I_REG_ADDR == `SPP_REG_CFG_A)
            port_cfg_ff[0] <= I_REG_WDATA[`SPP_CFG_W-1:0];
        else if (I_REG_WR && I_REG_ADDR == `SPP_REG_CFG_B)
            port_cfg_ff[1] <= I_REG_WDATA[`SPP_CFG_W-1:0];
    end

    // forwarding matrix, one row of permitted targets per ingress port
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            for (int r = 0; r < 3; r++)
                fwd_ff[r] <= FWD_RST[r*`SPP_FWD_STRIDE +: 3];
        end
        else if (I_REG_WR && I_REG_ADDR == `SPP_REG_FWD)
        begin
            for (int r = 0; r < 3; r++)
                fwd_ff[r] <= I_REG_WDATA[r*`SPP_FWD_STRIDE +: 3];
        end
    end

    // discovery mode of the two external ports
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            disc_ff[0] <= SPP_DISC_OFF;
            disc_ff[1] <= SPP_DISC_OFF;
        end
        else if (I_REG_WR && I_REG_ADDR == `SPP_REG_DISC)
        begin
            for (int d = 0; d < 2; d++)
                disc_ff[d] <= I_REG_WDATA[d*`SPP_DISC_STRIDE +: 2];
        end
    end

    // mirror role of each of the three ports
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            for (int m = 0; m < 3; m++)
                mir_ff[m] <= SPP_MIR_OFF;
        end
        else if (I_REG_WR && I_REG_ADDR == `SPP_REG_MIR)
        begin
            for (int m = 0; m < 3; m++)
                mir_ff[m] <= I_REG_WDATA[m*`SPP_MIR_STRIDE +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phy mode control and resolved link state

    spp_sync2 #(
        .W(4)
    ) u_link_sync (
        .i_clk(I_SYS_CLK),
        .i_reset_n(I_RESET_N),
        .i_d({I_LINK_FULL, I_LINK_100}),
        .o_q({link_full_s, link_100_s})
    );

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_phy
            spp_speed_t spd;
            spp_dup_t dup;
            logic adv_fixed;
            logic [1:0] spd_set;
            logic [1:0] dup_set;

            assign spd = spp_speed_t'(port_cfg_ff[g][`SPP_CFG_SPD_LSB +: 2]);
            assign dup = spp_dup_t'(port_cfg_ff[g][`SPP_CFG_DUP_LSB +: 2]);
            assign adv_fixed = port_cfg_ff[g][`SPP_CFG_ADV_BIT];
            // allowed speeds {100,10} and duplexes {full,half}
            assign spd_set = (spd == SPP_SPD_10) ? 2'h1 :
                             (spd == SPP_SPD_100) ? 2'h2 : 2'h3;
            assign dup_set = (dup == SPP_DUP_HALF) ? 2'h1 :
                             (dup == SPP_DUP_FULL) ? 2'h2 : 2'h3;

            // negotiation stays on for fixed modes when advertising them
            always_ff @(posedge I_SYS_CLK)
            begin
                if (!I_RESET_N)
                begin
                    O_ANEG_EN[g] <= 1'b1;
                    O_FORCE_100[g] <= 1'b0;
                    O_FORCE_FULL[g] <= 1'b0;
                    O_ADV_ABIL[g*4 +: 4] <= 4'hF;
                end
                else
                begin
                    O_ANEG_EN[g] <= spd == SPP_SPD_ANEG ||
                        dup == SPP_DUP_ANEG || adv_fixed;
                    O_FORCE_100[g] <= (spd == SPP_SPD_100);
                    O_FORCE_FULL[g] <= (dup == SPP_DUP_FULL);
                    // ability bits: 10h, 10f, 100h, 100f
                    O_ADV_ABIL[g*4 +: 4] <= {spd_set[1] & dup_set[1],
                        spd_set[1] & dup_set[0], spd_set[0] & dup_set[1],
                        spd_set[0] & dup_set[0]};
                end
            end

            // resolved state: negotiated result or the forced value
            assign eff_100[g] = (spd == SPP_SPD_ANEG) ? link_100_s[g] :
                                (spd == SPP_SPD_100);
            assign eff_full[g] = (dup == SPP_DUP_ANEG) ? link_full_s[g] :
                                 (dup == SPP_DUP_FULL);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // inbound limiters and discovery transmit timers

    logic [1:0] lim_ok;
    logic [1:0] lim_charge;
    logic [1:0] lim_class;
    logic [1:0] disc_pulse_ff;

    generate
        for (g = 0; g < 2; g++)
        begin : g_ext
            spp_lim_t lmode;
            logic [10:0] rate;
            logic [31:0] disc_cnt_ff;
            logic sends;

            assign lmode = spp_lim_t'(port_cfg_ff[g][`SPP_CFG_LIM_LSB +: 2]);
            assign rate = (lmode == SPP_LIM_BC) ? `SPP_LIM_BC_KBPS :
                          (lmode == SPP_LIM_MCBC) ? `SPP_LIM_MC_KBPS :
                          11'h000;
            // which frames of this port fall under the limiter
            assign lim_class[g] = (lmode == SPP_LIM_BC && I_RX_BCAST) ||
                (lmode == SPP_LIM_MCBC && (I_RX_BCAST || I_RX_MCAST));
            assign lim_charge[g] = I_RX_VALID && lim_class[g] &&
                I_RX_PORT == 2'(g);

            spp_rate_limiter #(
                .LEN_W(LEN_W)
            ) u_lim (
                .i_clk(I_SYS_CLK),
                .i_reset_n(I_RESET_N),
                .i_rate_kbps(rate),
                .i_len(I_RX_LEN),
                .i_charge(lim_charge[g]),
                .o_ok(lim_ok[g])
            );

            // periodic trigger for the discovery frame transmitter
            assign sends = disc_ff[g] == SPP_DISC_SEND ||
                disc_ff[g] == SPP_DISC_BOTH;

            always_ff @(posedge I_SYS_CLK)
            begin
                if (!I_RESET_N)
                begin
                    disc_cnt_ff <= '0;
                    disc_pulse_ff[g] <= 1'b0;
                end
                else if (!sends)
                begin
                    disc_cnt_ff <= '0;
                    disc_pulse_ff[g] <= 1'b0;
                end
                else if (disc_cnt_ff == 32'(DISC_PERIOD_CYC - 1))
                begin
                    disc_cnt_ff <= '0;
                    disc_pulse_ff[g] <= 1'b1;
                end
                else
                begin
                    disc_cnt_ff <= disc_cnt_ff + 32'h1;
                    disc_pulse_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign O_DISC_SEND = disc_pulse_ff;

    ////////////////////////////////////////////////////////////////////////
    // per-frame decision

    logic ext_port;
    logic port_ok;
    logic is_disc;
    logic lim_drop;
    logic [2:0] fwd;
    logic deliver;
    logic [2:0] egr_set;
    logic [2:0] ing_set;
    logic [1:0] dest_idx;
    logic dest_vld;
    logic want_mir;

    // lowest-numbered port in destination role takes the copies
    always_comb
    begin
        dest_idx = `SPP_PORT_A;
        dest_vld = 1'b0;
        for (int m = 2; m >= 0; m--)
        begin
            if (mir_ff[m] == SPP_MIR_DEST)
            begin
                dest_idx = 2'(m);
                dest_vld = 1'b1;
            end
        end
    end

    // which ports copy their outgoing or incoming traffic
    always_comb
    begin
        for (int m = 0; m < 3; m++)
        begin
            egr_set[m] = mir_ff[m] == SPP_MIR_EGR ||
                mir_ff[m] == SPP_MIR_BOTH;
            ing_set[m] = mir_ff[m] == SPP_MIR_ING ||
                mir_ff[m] == SPP_MIR_BOTH;
        end
    end

    // discovery frames from the external ports never get forwarded; they are delivered or dropped
    always_comb
    begin
        ext_port = I_RX_PORT == `SPP_PORT_A || I_RX_PORT == `SPP_PORT_B;
        port_ok = ext_port || I_RX_PORT == `SPP_PORT_CPU;
        is_disc = ext_port && I_RX_DISC;
        deliver = is_disc && (disc_ff[I_RX_PORT[0]] == SPP_DISC_RECV ||
            disc_ff[I_RX_PORT[0]] == SPP_DISC_BOTH);
        lim_drop = ext_port && lim_class[I_RX_PORT[0]] &&
            !lim_ok[I_RX_PORT[0]];
        fwd = 3'h0;
        if (port_ok && !is_disc && !lim_drop)
            fwd = I_RX_DEST & fwd_ff[I_RX_PORT] &
                ~(3'h1 << I_RX_PORT);
        want_mir = dest_vld && port_ok && I_RX_PORT != dest_idx &&
            (ing_set[I_RX_PORT] || |(fwd & egr_set));
    end

    // decision outputs stand for one cycle after the request
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            O_DEC_VALID <= 1'b0;
            O_DEC_FWD <= 3'h0;
            O_DEC_DROP <= 1'b0;
            O_DEC_DISC_DELIVER <= 1'b0;
            O_DEC_MIRROR <= 1'b0;
            O_MIR_PORT <= `SPP_PORT_A;
        end
        else
        begin
            O_DEC_VALID <= I_RX_VALID;
            O_DEC_FWD <= I_RX_VALID ? fwd : 3'h0;
            O_DEC_DROP <= I_RX_VALID && fwd == 3'h0 && !deliver;
            O_DEC_DISC_DELIVER <= I_RX_VALID && deliver;
            // no room at the mirror port: the copy alone is lost
            O_DEC_MIRROR <= I_RX_VALID && want_mir && I_MIR_READY;
            O_MIR_PORT <= dest_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // drop counters, wrap around, cleared only by reset

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
            lim_drop_ff <= '0;
        else if (I_RX_VALID && lim_drop && !is_disc)
            lim_drop_ff <= lim_drop_ff + 1'b1;
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
            mir_drop_ff <= '0;
        else if (I_RX_VALID && want_mir && !I_MIR_READY)
            mir_drop_ff <= mir_drop_ff + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // register read, data one cycle after the strobe, zero elsewhere

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
            O_REG_RDATA <= 32'h0;
        else if (!I_REG_RD)
            O_REG_RDATA <= 32'h0;
        else
        begin
            case (I_REG_ADDR)
                `SPP_REG_CFG_A: O_REG_RDATA <= 32'(port_cfg_ff[0]);
                `SPP_REG_CFG_B: O_REG_RDATA <= 32'(port_cfg_ff[1]);
                `SPP_REG_FWD: O_REG_RDATA <= {20'h0, 1'b0, fwd_ff[2],
                    1'b0, fwd_ff[1], 1'b0, fwd_ff[0]};
                `SPP_REG_DISC: O_REG_RDATA <= {28'h0, disc_ff[1], disc_ff[0]};
                `SPP_REG_MIR: O_REG_RDATA <= {20'h0, 1'b0, mir_ff[2],
                    1'b0, mir_ff[1], 1'b0, mir_ff[0]};
                `SPP_REG_STAT: O_REG_RDATA <= {28'h0, eff_full[1], eff_100[1],
                    eff_full[0], eff_100[0]};
                `SPP_REG_LIM_DROP: O_REG_RDATA <= 32'(lim_drop_ff);
                `SPP_REG_MIR_DROP: O_REG_RDATA <= 32'(mir_drop_ff);
                default: O_REG_RDATA <= 32'h0;
            endcase
        end
    end

endmodule // spp_switch_port_policy

// File: dv/spp_link_partner.sv
// far side model: link partners on the external ports and the mirror sink
`timescale 1ns/1ps
module spp_link_partner (
    input wire logic i_clk,
    input wire logic [1:0] i_aneg_en,
    input wire logic [1:0] i_force_100,
    input wire logic [1:0] i_force_full,
    input wire logic i_stall,
    output logic [1:0] o_link_100,
    output logic [1:0] o_link_full,
    output logic o_mir_ready
);
    // partners can do 100 full, so negotiation settles at the top mode
    always_ff @(posedge i_clk)
    begin
        o_link_100 <= i_aneg_en | i_force_100;
        o_link_full <= i_aneg_en | i_force_full;
        o_mir_ready <= !i_stall;
    end
endmodule // spp_link_partner

// File: dv/spp_policy_sva.sv
// assertion checker for the switch port policy block, bound to its top
`timescale 1ns/1ps
module spp_policy_sva (
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    input wire logic I_RX_VALID,
    input wire logic [1:0] I_RX_PORT,
    input wire logic I_RX_DISC,
    input wire logic [2:0] I_RX_DEST,
    input wire logic I_MIR_READY,
    input wire logic O_DEC_VALID,
    input wire logic [2:0] O_DEC_FWD,
    input wire logic O_DEC_DROP,
    input wire logic O_DEC_DISC_DELIVER,
    input wire logic O_DEC_MIRROR,
    input wire logic [1:0] O_DISC_SEND
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_rx_taken;
        I_RX_VALID;
    endsequence
    sequence s_ext_disc;
        I_RX_VALID && I_RX_DISC && I_RX_PORT != 2'h2;
    endsequence
////////////////////////////////////////////////////////////////////////////
    dec_follows_rx_a:
        assert property (s_rx_taken |=> O_DEC_VALID)
        else $error("no decision one cycle after a descriptor");
    dec_has_cause_a:
        assert property (O_DEC_VALID |-> $past(I_RX_VALID))
        else $error("decision without a descriptor");
    fwd_idle_zero_a:
        assert property (!O_DEC_VALID |-> O_DEC_FWD == 3'h0)
        else $error("forward mask set outside a decision");
    fwd_in_lookup_a:
        assert property (s_rx_taken
            |=> (O_DEC_FWD & ~$past(I_RX_DEST)) == 3'h0)
        else $error("frame sent outside its lookup mask");
    own_port_clear_a:
        assert property (I_RX_VALID && I_RX_PORT != 2'h3
            |=> !O_DEC_FWD[$past(I_RX_PORT)])
        else $error("frame sent back to its ingress port");
    disc_no_fwd_a:
        assert property (s_ext_disc |=> O_DEC_FWD == 3'h0)
        else $error("discovery frame forwarded");
    drop_excl_a:
        assert property (O_DEC_DROP |-> O_DEC_VALID && O_DEC_FWD == 3'h0
            && !O_DEC_DISC_DELIVER)
        else $error("dropped frame still forwarded or delivered");
    deliver_disc_a:
        assert property (O_DEC_DISC_DELIVER |-> $past(I_RX_DISC && I_RX_VALID))
        else $error("delivery of a frame that is not discovery");
    mir_ready_a:
        assert property (O_DEC_MIRROR |-> O_DEC_VALID && $past(I_MIR_READY))
        else $error("mirror copy while the mirror port was busy");
    disc_pulse_a:
        assert property (O_DISC_SEND[0] |=> !O_DISC_SEND[0] [*8])
        else $error("discovery send pulses too close together");
endmodule // spp_policy_sva

bind spp_switch_port_policy spp_policy_sva spp_policy_sva_inst (
    .I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .I_RX_VALID(I_RX_VALID),
    .I_RX_PORT(I_RX_PORT), .I_RX_DISC(I_RX_DISC), .I_RX_DEST(I_RX_DEST),
    .I_MIR_READY(I_MIR_READY), .O_DEC_VALID(O_DEC_VALID),
    .O_DEC_FWD(O_DEC_FWD), .O_DEC_DROP(O_DEC_DROP),
    .O_DEC_DISC_DELIVER(O_DEC_DISC_DELIVER), .O_DEC_MIRROR(O_DEC_MIRROR),
    .O_DISC_SEND(O_DISC_SEND)
);

// File: dv/test_switch_port_policy.sv
// self-checking bench for the switch port policy block
`timescale 1ns/1ps
module test_switch_port_policy;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, vld = 1'b0;
    logic stall = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [10:0] len = 11'h000;
    logic [1:0] port = 2'h0;
    logic [2:0] kind = 3'h0, dest = 3'h0;
    logic [31:0] rdata;
    logic [1:0] l100, lfull, aneg, f100, ffull, mport, dsend;
    logic [7:0] adv;
    logic [2:0] fwd;
    logic dv, drop, dlv, mir, mrdy;
    int bad_count = 0, compares = 0, na, nb;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h14};
    logic [31:0] rv [7] = '{32'h30, 32'h30, 32'h356, 0, 0, 0, 32'hF};
    logic [31:0] cw [3] = '{32'h3A, 32'h35, 32'h30};
    logic [6:0] ce [3] = '{7'h64, 7'h52, 7'h4F};
////////////////////////////////////////////////////////////////////////////
    // short disc period keeps the discovery scenario brief
    spp_switch_port_policy #(.DISC_PERIOD_CYC(50))
    spp_switch_port_policy_inst (
        .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_REG_ADDR(addr),
        .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
        .I_LINK_100(l100), .I_LINK_FULL(lfull), .O_ANEG_EN(aneg),
        .O_FORCE_100(f100), .O_FORCE_FULL(ffull), .O_ADV_ABIL(adv),
        .I_RX_VALID(vld), .I_RX_PORT(port), .I_RX_LEN(len),
        .I_RX_BCAST(kind[0]), .I_RX_MCAST(kind[1]), .I_RX_DISC(kind[2]),
        .I_RX_DEST(dest), .I_MIR_READY(mrdy), .O_DEC_VALID(dv),
        .O_DEC_FWD(fwd), .O_DEC_DROP(drop), .O_DEC_DISC_DELIVER(dlv),
        .O_DEC_MIRROR(mir), .O_MIR_PORT(mport), .O_DISC_SEND(dsend)
    );
    spp_link_partner spp_link_partner_inst (
        .i_clk(clk), .i_aneg_en(aneg), .i_force_100(f100),
        .i_force_full(ffull), .i_stall(stall), .o_link_100(l100),
        .o_link_full(lfull), .o_mir_ready(mrdy)
    );
////////////////////////////////////////////////////////////////////////////
    // compare, count and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // register writes and reads; read data stands only one cycle
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd32(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // one descriptor; x is {mirror, deliver}, drop follows from the rest
    task automatic frm(input logic [1:0] p, input logic [10:0] n,
        input logic [2:0] k, input logic [2:0] f, input logic [2:0] e,
        input logic [1:0] x);
        @(posedge clk);
        {vld, port, len, kind, dest} <= {1'b1, p, n, k, f};
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk({dv, fwd, mir, dlv, drop}, {1'b1, e, x, e == 3'h0 && !x[0]});
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////
    initial
        forever #25 clk = ~clk;
    // a hang counts as a failure
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({aneg, f100, ffull, adv, mport, dsend}, 18'h30FF0);
        foreach (ra[i]) rd32(ra[i], rv[i]);
        foreach (cw[i])
        begin
            wr32(8'h00, cw[i]);
            repeat (2) @(posedge clk);
            #1;
            chk({aneg[0], f100[0], ffull[0], adv[3:0]}, ce[i]);
        end
        // advertise off with fixed values, then check the resolved link
        wr32(8'h00, 32'h2A);
        repeat (6) @(posedge clk);
        #1;
        chk({aneg[0], f100[0], ffull[0]}, 3'b010);
        rd32(8'h14, 32'hD);
        wr32(8'h00, 32'h30);
        frm(2'h0, 11'd64, 3'h0, 3'b111, 3'b110, 2'b00);
        frm(2'h2, 11'd64, 3'h0, 3'b011, 3'b011, 2'b00);
        wr32(8'h08, 32'h354);
        frm(2'h0, 11'd64, 3'h0, 3'b110, 3'b100, 2'b00);
        frm(2'h1, 11'd64, 3'h0, 3'b101, 3'b101, 2'b00);
        wr32(8'h08, 32'h356);
        // bucket holds 2048 bytes, so the third broadcast is refused
        repeat (2) frm(2'h0, 11'd1024, 3'h1, 3'b110, 3'b110, 2'b00);
        frm(2'h0, 11'd1024, 3'h1, 3'b110, 3'b000, 2'b00);
        frm(2'h0, 11'd1024, 3'h2, 3'b110, 3'b110, 2'b00);
        wr32(8'h04, 32'h50);
        frm(2'h1, 11'd1500, 3'h2, 3'b101, 3'b101, 2'b00);
        frm(2'h1, 11'd1000, 3'h1, 3'b101, 3'b000, 2'b00);
        rd32(8'h18, 32'h2);
        wr32(8'h00, 32'h10);
        frm(2'h0, 11'd1024, 3'h1, 3'b110, 3'b110, 2'b00);
        for (int m = 0; m < 4; m++)
        begin
            wr32(8'h0C, m);
            frm(2'h0, 11'd64, 3'h4, 3'b110, 3'b000, {1'b0, m[1]});
            frm(2'h1, 11'd64, 3'h4, 3'b101, 3'b000, 2'b00);
            na = 0;
            nb = 0;
            repeat (100)
            begin
                @(posedge clk);
                #1;
                na += dsend[0];
                nb += dsend[1];
            end
            chk({na[7:0], nb[7:0]}, {m[0] ? 8'h02 : 8'h00, 8'h00});
        end
        wr32(8'h0C, 32'h0);
        // processor port is the mirror destination, port a cycles modes
        for (int m = 0; m < 4; m++)
        begin
            wr32(8'h10, 32'h400 | m);
            frm(2'h0, 11'd64, 3'h0, 3'b010, 3'b010, {m[1], 1'b0});
            frm(2'h1, 11'd64, 3'h0, 3'b001, 3'b001, {m[0], 1'b0});
            chk(mport, 32'h2);
        end
        stall <= 1'b1;
        frm(2'h0, 11'd64, 3'h0, 3'b010, 3'b010, 2'b00);
        stall <= 1'b0;
        rd32(8'h1C, 32'h1);
        complete_run();
    end
endmodule // test_switch_port_policy
